//--- hw/cwh_map.svh
// Purpose: constants of the coordinate wrap and home manager
// Assumes: 32-bit APB data, one word per register
// Notes: included by the package and the top module
// Function
// - wrap on: present position re-presets to stay within the wrap range
// - wrap on by default; off needs manual coordinate mode and wrap bit 0
// - wrap presets never touch the 32-bit step counter
// - leaving an offset range at one end continues from the other end
// - step counter reports position in steps, wrap on or off
// - step counter is signed, rolls max to min, never saturates
// - step counter is readable by a network monitor read
// - coordinates-valid output is high whenever coordinates are set and no homing is busy
// - unset coordinates refuse fast homing; absolute moves unless permitted
// - factory home present in sensor raises factory-home output
// - user home set by homing or preset: flag high, stored in nvm
// - no network request unsets user home; only the tool clear or a resolution change after a nonzero preset does
// - preset loads command and feedback position with preset value
// - electrical-home request rise captures command position as home
// - electrical-home-active output high while electrical home is set
// - electrical-home request fall clears it, back to mechanical home
// - electrical home is never written to non-volatile memory
// - preset or homing with request high sets both homes together
// - fast homing refused while electrical-home coordinates are used
// - coordinates unset: factory, resolution change after a nonzero preset, clear, homing
// - initial coordinates come from wrap settings read at power-on
`ifndef CWH_MAP_SVH
`define CWH_MAP_SVH
// ==========================================================
// register byte offsets
`define CWH_OFS_CTRL 8'h00
`define CWH_OFS_RANGE 8'h04
`define CWH_OFS_LOW 8'h08
`define CWH_OFS_PRESET 8'h0c
`define CWH_OFS_CMD 8'h10
`define CWH_OFS_STATUS 8'h14
`define CWH_OFS_COUNT 8'h18
`define CWH_OFS_POS 8'h1c
`define CWH_OFS_EHOME 8'h20
// ==========================================================
// control bits
`define CWH_CTRL_WRAP 0
`define CWH_CTRL_MANUAL 1
`define CWH_CTRL_ABSOK 2
// command bits (write one)
`define CWH_CMD_PRESET 0
`define CWH_CMD_APPLY 1
// ==========================================================
// reset values
`define CWH_CTRL_RST 3'h1
`define CWH_RANGE_RST 32'h0003_e800
`define CWH_LOW_RST 32'hfffe_0c00
`define CWH_PRESET_RST 32'h0000_0000
`define CWH_SENSOR_REVS 1800
`endif

//--- hw/cwh_pkg.sv
// Purpose: shared types of the coordinate wrap and home manager
// Assumes: constants live in cwh_map.svh
// Notes: carriers for the APB request and the status word
`include "cwh_map.svh"
package cwh_pkg;
  // ==========================================================
  // apb request fields that travel together
  typedef struct packed {
    logic [7:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } cwh_apb_req_t;
  // home and coordinate status
  typedef struct packed {
    logic home_busy;
    logic elec_active;
    logic user_home;
    logic factory_home;
    logic coord_valid;
  } cwh_status_t;
endpackage : cwh_pkg

//--- hw/cwh_top.sv
// Purpose: wrap coordinates, step counter, mechanical and electrical homes
// Assumes: step and homing inputs come from core_clk_i logic
// Notes: pins el_home, factory, tool clear are synchronised here
//
// Chosen here: the address map and the APB slave port.
`include "cwh_map.svh"
module cwh_top import cwh_pkg::*; #(
  parameter int STEP_W = 32
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire cwh_apb_req_t apb_req_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic step_i,
  input wire logic step_dir_i,
  input wire logic home_busy_i,
  input wire logic home_done_i,
  input wire logic res_change_i,
  input wire logic zhome_req_i,
  input wire logic abs_req_i,
  input wire logic nvm_home_valid_i,
  input wire logic factory_home_pin_i,
  input wire logic electrical_home_request_i,
  input wire logic tool_clear_pin_i,
  output logic zhome_ok_o,
  output logic abs_ok_o,
  output logic nvm_write_o,
  output logic [31:0] step_count_o,
  output logic [31:0] present_pos_o,
  output cwh_status_t status_o
);
  // ==========================================================
  // elaboration checks
  if (STEP_W != 32) begin : g_chk
    $error("cwh_top: STEP_W must be 32");
  end

  // ==========================================================
  // pin synchronisers, three flops so edges read stage two
  logic [2:0] el_sync_q;
  logic [2:0] fac_sync_q;
  logic [2:0] clr_sync_q;
  logic el_rise;
  logic el_fall;
  logic clr_pulse;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      el_sync_q <= 3'h0;
      fac_sync_q <= 3'h0;
      clr_sync_q <= 3'h0;
    end else begin
      el_sync_q <= {el_sync_q[1:0], electrical_home_request_i};
      fac_sync_q <= {fac_sync_q[1:0], factory_home_pin_i};
      clr_sync_q <= {clr_sync_q[1:0], tool_clear_pin_i};
    end
  end
  assign el_rise = el_sync_q[1] & ~el_sync_q[2];
  assign el_fall = ~el_sync_q[1] & el_sync_q[2];
  assign clr_pulse = clr_sync_q[1] & ~clr_sync_q[2];

  // ==========================================================
  // apb register file
  logic [2:0] ctrl_q;
  logic [31:0] range_q;
  logic [31:0] low_q;
  logic [31:0] preset_q;
  logic wr_en;
  logic rd_setup;
  logic hit;
  logic preset_cmd;
  logic apply_cmd;
  assign wr_en = psel_i & penable_i & apb_req_i.pwrite;
  assign rd_setup = psel_i & ~penable_i;
  // writes land only at the access edge
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl_q <= `CWH_CTRL_RST;
      range_q <= `CWH_RANGE_RST;
      low_q <= `CWH_LOW_RST;
      preset_q <= `CWH_PRESET_RST;
    end else if (wr_en) begin
      case (apb_req_i.paddr)
        `CWH_OFS_CTRL: ctrl_q <= apb_req_i.pwdata[2:0];
        `CWH_OFS_RANGE: range_q <= apb_req_i.pwdata;
        `CWH_OFS_LOW: low_q <= apb_req_i.pwdata;
        `CWH_OFS_PRESET: preset_q <= apb_req_i.pwdata;
        default: ;
      endcase
    end
  end
  assign preset_cmd = wr_en && apb_req_i.paddr == `CWH_OFS_CMD
                      && apb_req_i.pwdata[`CWH_CMD_PRESET];
  assign apply_cmd = wr_en && apb_req_i.paddr == `CWH_OFS_CMD
                     && apb_req_i.pwdata[`CWH_CMD_APPLY];

  // address decode for the error path only; the read path decodes on its own
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `CWH_OFS_CTRL, `CWH_OFS_RANGE, `CWH_OFS_LOW, `CWH_OFS_PRESET,
      `CWH_OFS_CMD, `CWH_OFS_STATUS, `CWH_OFS_COUNT, `CWH_OFS_POS,
      `CWH_OFS_EHOME: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped
  assign hit = mapped(apb_req_i.paddr);
  // zero wait state; error on unmapped access
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit;

  // ==========================================================
  // wrap settings taken at power-on or on apply
  logic load_q;
  logic wrap_act_q;
  logic [31:0] lo_act_q;
  logic [31:0] hi_act_q;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      load_q <= 1'b1;
    end else begin
      load_q <= apply_cmd;
    end
  end
  // wrap may only be turned off in manual mode
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wrap_act_q <= 1'b1;
      lo_act_q <= `CWH_LOW_RST;
      hi_act_q <= 32'(`CWH_LOW_RST + `CWH_RANGE_RST - 32'h1);
    end else if (load_q) begin
      wrap_act_q <= ~ctrl_q[`CWH_CTRL_MANUAL] | ctrl_q[`CWH_CTRL_WRAP];
      lo_act_q <= low_q;
      hi_act_q <= 32'(low_q + range_q - 32'h1); // range must fit
    end
  end

  // ==========================================================
  // next wrapped position; opposite end on overrun
  function automatic logic [31:0] wrap_step(
    input logic [31:0] p, input logic dir, input logic w,
    input logic [31:0] lo, input logic [31:0] hi);
    logic [31:0] n;
    n = dir ? 32'(p + 32'h1) : 32'(p - 32'h1);
    if (w && dir && $signed(p) >= $signed(hi)) begin
      n = lo;
    end else if (w && !dir && $signed(p) <= $signed(lo)) begin
      n = hi;
    end
    return n;
  endfunction : wrap_step

  // ==========================================================
  // free running signed step counter
  logic [31:0] count_q;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      count_q <= 32'h0;
    end else if (step_i) begin
      // plain add rolls max to min, no preset ever
      count_q <= step_dir_i ? 32'(count_q + 32'h1)
                            : 32'(count_q - 32'h1);
    end
  end
  assign step_count_o = count_q;

  // ==========================================================
  // present (command = feedback) position
  logic [31:0] pos_q;
  logic home_set;
  assign home_set = preset_cmd | home_done_i;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pos_q <= 32'h0;
    end else if (home_set) begin
      pos_q <= preset_q;
    end else if (step_i) begin
      pos_q <= wrap_step(pos_q, step_dir_i, wrap_act_q,
                         lo_act_q, hi_act_q);
    end
  end

  // ==========================================================
  // electrical home, volatile only
  logic el_act_q;
  logic [31:0] ehome_q;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      el_act_q <= 1'b0;
      ehome_q <= 32'h0;
    end else if (el_fall) begin
      el_act_q <= 1'b0;
      ehome_q <= 32'h0;
    end else if (home_set && el_sync_q[2]) begin
      el_act_q <= 1'b1;
      ehome_q <= 32'h0; // both systems read preset
    end else if (el_rise) begin
      el_act_q <= 1'b1;
      ehome_q <= pos_q;
    end
  end
  // coordinates centred on the electrical home while active
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      present_pos_o <= 32'h0;
    end else begin
      present_pos_o <= el_act_q ? 32'(pos_q - ehome_q) : pos_q;
    end
  end

  // ==========================================================
  // mechanical homes and coordinate state
  logic fac_q;
  logic user_q;
  logic strap_q;
  logic preset_nz_q;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      fac_q <= 1'b0;
    end else begin
      fac_q <= fac_sync_q[1];
    end
  end
  // user home: set wins over clear; nvm state caught after release
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      user_q <= 1'b0;
      strap_q <= 1'b1;
      preset_nz_q <= 1'b0;
    end else begin
      strap_q <= 1'b0;
      if (home_set) begin
        user_q <= 1'b1;
        preset_nz_q <= preset_cmd && preset_q != 32'h0;
      end else if (clr_pulse) begin
        user_q <= 1'b0; // tool pin only, no apb path
        preset_nz_q <= 1'b0;
      end else if (res_change_i && preset_nz_q) begin
        user_q <= 1'b0;
        preset_nz_q <= 1'b0;
      end else if (strap_q) begin
        user_q <= nvm_home_valid_i;
      end
    end
  end
  // only the mechanical user home goes to nvm
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      nvm_write_o <= 1'b0;
    end else begin
      nvm_write_o <= home_set;
    end
  end

  logic valid;
  assign valid = (user_q | fac_q) & ~home_busy_i;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      status_o <= '0;
    end else begin
      status_o.coord_valid <= valid;
      status_o.factory_home <= fac_q;
      status_o.user_home <= user_q;
      status_o.elec_active <= el_act_q;
      status_o.home_busy <= home_busy_i;
    end
  end

  // ==========================================================
  // operation gating towards the motion logic
  assign zhome_ok_o = zhome_req_i & valid & ~el_act_q;
  assign abs_ok_o = abs_req_i
                    & (valid | ctrl_q[`CWH_CTRL_ABSOK]);

  // ==========================================================
  // read data captured in setup, held through access
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0;
    end else if (rd_setup) begin
      case (apb_req_i.paddr)
        `CWH_OFS_CTRL: prdata_o <= {29'h0, ctrl_q};
        `CWH_OFS_RANGE: prdata_o <= range_q;
        `CWH_OFS_LOW: prdata_o <= low_q;
        `CWH_OFS_PRESET: prdata_o <= preset_q;
        `CWH_OFS_STATUS: prdata_o <= {27'h0, status_o};
        `CWH_OFS_COUNT: prdata_o <= count_q;
        `CWH_OFS_POS: prdata_o <= present_pos_o;
        `CWH_OFS_EHOME: prdata_o <= ehome_q;
        default: prdata_o <= 32'h0;
      endcase
    end
  end

  // ==========================================================
  // checks
  AST_CNT_STEP: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    step_i |=> count_q == 32'($past(count_q) + ($past(step_dir_i)
      ? 32'h1 : 32'hffff_ffff)))
    else $error("step counter off");
  AST_CNT_ROLL: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    step_i && step_dir_i && count_q == 32'h7fff_ffff
    |=> count_q == 32'h8000_0000)
    else $error("counter did not roll");
  AST_CNT_HOLD: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    !step_i |=> $stable(count_q))
    else $error("counter moved on preset");
  AST_WRAP_HI: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    step_i && step_dir_i && wrap_act_q && !home_set && pos_q == hi_act_q
    |=> pos_q == lo_act_q)
    else $error("no wrap at top");
  AST_PRESET: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    home_set |=> pos_q == $past(preset_q) ##1 status_o.user_home)
    else $error("preset not applied");
  AST_EL_RISE: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    el_rise && !el_fall && !home_set |=> el_act_q
    && ehome_q == $past(pos_q))
    else $error("electrical home not captured");
  AST_EL_FALL: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    el_fall |=> !el_act_q ##1 !status_o.elec_active)
    else $error("electrical home not cleared");
  // synced request high means electrical coordinates are in use
  AST_ZHOME: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    zhome_req_i && el_sync_q[2] |-> !zhome_ok_o)
    else $error("fast homing not refused");
  AST_BUSY: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    home_busy_i |=> !status_o.coord_valid)
    else $error("valid during homing");
  AST_ABS: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    abs_req_i && !valid && !ctrl_q[`CWH_CTRL_ABSOK] |-> !abs_ok_o)
    else $error("absolute move not refused");
  AST_CLR: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    clr_pulse && !home_set |=> !user_q)
    else $error("tool clear ignored");
  AST_RES_CHG: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    res_change_i && preset_nz_q && !home_set && !clr_pulse |=> !user_q)
    else $error("resolution change kept home");
  AST_NVM_SET: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    home_set |=> nvm_write_o)
    else $error("user home not stored");
  AST_NVM_EL: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    el_rise && !home_set |=> !nvm_write_o)
    else $error("electrical home stored");
endmodule : cwh_top

//--- tb/cwh_host.sv
// Purpose: host controller model, apb master of the register bus
// Assumes: slave may add wait states; pready sampled at rising edge
// Notes: tmo_o rises when an answer never comes
module cwh_host import cwh_pkg::*; (
  input wire logic clk_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  input wire logic [31:0] prdata_i,
  output logic psel_o,
  output logic penable_o,
  output cwh_apb_req_t req_o,
  output logic tmo_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // idle bus at time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    req_o = '0;
    tmo_o = 1'b0;
  end
  // ==========================================================
  // one transfer; request held until pready seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    req_o <= '{paddr: a, pwrite: w, pwdata: d};
    @(posedge clk_i);
    penable_o <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_i !== 1'b1 && n < 50);
    if (pready_i !== 1'b1) tmo_o <= 1'b1; // a hung slave must not hang
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask : xfer
endmodule : cwh_host

//--- tb/test_coordinate_wrap_and_home_manager.sv
// Purpose: self-checking bench of the coordinate wrap and home manager
// Assumes: zero-wait apb slave, wrap settings taken on apply command
// Notes: integer model of count, wrapped position and homes
`include "cwh_map.svh"
module test_coordinate_wrap_and_home_manager import cwh_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel, pen, stp, sdir, busy, zreq, areq, fpin, epin, cpin, tmo;
  logic hdone, rchg, nvm;
  logic pready, perr, zok, aok, nvmw, e;
  cwh_apb_req_t req;
  cwh_status_t st;
  logic [31:0] prdata, cnt_o, pos_o, q, rng;
  int fails, n_checks, nwr, cnt, pos, eh, lo, hi;
  bit wrap;
  logic [7:0] ofs [4] = '{`CWH_OFS_CTRL, `CWH_OFS_RANGE, `CWH_OFS_LOW,
    `CWH_OFS_PRESET};
  logic [31:0] rv [4] = '{32'(`CWH_CTRL_RST), `CWH_RANGE_RST,
    `CWH_LOW_RST, `CWH_PRESET_RST};
  // ==========================================================
  // clock, design and host
  always #2 clk = ~clk;
  cwh_top u_dut (.core_clk_i(clk), .reset_i(rst), .psel_i(psel),
    .penable_i(pen), .apb_req_i(req), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(perr), .step_i(stp),
    .step_dir_i(sdir), .home_busy_i(busy), .home_done_i(hdone),
    .res_change_i(rchg), .zhome_req_i(zreq), .abs_req_i(areq),
    .nvm_home_valid_i(nvm), .factory_home_pin_i(fpin),
    .electrical_home_request_i(epin), .tool_clear_pin_i(cpin),
    .zhome_ok_o(zok), .abs_ok_o(aok), .nvm_write_o(nvmw),
    .step_count_o(cnt_o), .present_pos_o(pos_o), .status_o(st));
  cwh_host u_host (.clk_i(clk), .pready_i(pready), .pslverr_i(perr),
    .prdata_i(prdata), .psel_o(psel), .penable_o(pen), .req_o(req),
    .tmo_o(tmo));
  // ==========================================================
  // helpers
  always @(posedge clk) if (nvmw === 1'b1) nwr++;
  always @(posedge tmo) begin
    fails++;
    final_report();
  end
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    u_host.xfer(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask : rdc
  // one step pulse, then model update and compare once settled
  task automatic step(input logic dir);
    @(posedge clk);
    stp <= 1'b1;
    sdir <= dir;
    @(posedge clk);
    stp <= 1'b0;
    cnt += dir ? 1 : -1;
    if (wrap && dir && pos == hi) pos = lo;
    else if (wrap && !dir && pos == lo) pos = hi;
    else pos += dir ? 1 : -1;
    repeat (2) @(posedge clk);
    chk(cnt_o, 32'(cnt));
    chk(pos_o, 32'(pos - eh));
  endtask : step
  // ==========================================================
  // main sequence
  initial begin
    rng = 32'd99334;
    {stp, sdir, busy, fpin, epin, cpin, hdone, rchg, nvm} = '0;
    {zreq, areq} = 2'b11;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rdc(ofs[i], rv[i]);
    chk(32'(st.coord_valid), 32'h0);
    chk(32'(zok), 32'h0);
    chk(32'(aok), 32'h0);
    u_host.xfer(1'b0, 8'h40, 32'h1, q, e);
    chk(q, 32'h0);
    chk(32'(e), 32'h1);
    // small range that divides evenly, offset to span both signs
    wr(`CWH_OFS_RANGE, 32'h6);
    wr(`CWH_OFS_LOW, 32'hffff_fffd);
    wr(`CWH_OFS_CMD, 32'h2);
    wr(`CWH_OFS_CMD, 32'h1);
    {lo, hi, wrap, pos, cnt, eh} = {-32'sd3, 32'sd2, 1'b1, 96'h0};
    repeat (4) @(posedge clk);
    chk(32'(st.user_home), 32'h1);
    chk(32'(nwr), 32'h1);
    chk(pos_o, 32'h0);
    chk(32'(zok), 32'h1);
    for (int i = 0; i < 4; i++) step(1'b1);
    for (int i = 0; i < 8; i++) step(1'b0);
    for (int i = 0; i < 60; i++) step(1'(rnd()));
    rdc(`CWH_OFS_COUNT, 32'(cnt));
    // electrical home in and out
    epin <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(st.elec_active), 32'h1);
    chk(pos_o, 32'h0);
    chk(32'(zok), 32'h0);
    epin <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(st.elec_active), 32'h0);
    chk(pos_o, 32'(pos));
    chk(32'(nwr), 32'h1);
    // wrap off: manual mode with wrap bit clear
    wr(`CWH_OFS_CTRL, 32'h2);
    wr(`CWH_OFS_CMD, 32'h2);
    wrap = 1'b0;
    for (int i = 0; i < 8; i++) step(1'b1);
    // preset while electrical request is high sets both homes
    epin <= 1'b1;
    repeat (8) @(posedge clk);
    wr(`CWH_OFS_PRESET, 32'h5);
    wr(`CWH_OFS_CMD, 32'h1);
    repeat (4) @(posedge clk);
    chk(pos_o, 32'h5);
    chk(32'(st.elec_active), 32'h1);
    rdc(`CWH_OFS_EHOME, 32'h0);
    epin <= 1'b0;
    repeat (8) @(posedge clk);
    chk(pos_o, 32'h5);
    chk(32'(nwr), 32'h2);
    pos = 5;
    // resolution change after a nonzero preset unsets coordinates
    rchg <= 1'b1;
    @(posedge clk);
    rchg <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(st.user_home), 32'h0);
    chk(32'(st.coord_valid), 32'h0);
    // completed homing sets the user home again at the preset value
    step(1'b1);
    hdone <= 1'b1;
    @(posedge clk);
    hdone <= 1'b0;
    repeat (4) @(posedge clk);
    chk(pos_o, 32'h5);
    chk(32'(st.user_home), 32'h1);
    chk(32'(st.coord_valid), 32'h1);
    chk(32'(nwr), 32'h3);
    // homing in progress, then permission for absolute moves
    busy <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(st.coord_valid), 32'h0);
    chk(32'(st.home_busy), 32'h1);
    chk(32'(zok), 32'h0);
    chk(32'(aok), 32'h0);
    wr(`CWH_OFS_CTRL, 32'h6);
    @(posedge clk);
    chk(32'(aok), 32'h1);
    busy <= 1'b0;
    // tool clear drops user home; factory home restores coordinates
    cpin <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(st.user_home), 32'h0);
    chk(32'(st.coord_valid), 32'h0);
    cpin <= 1'b0;
    fpin <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(st.factory_home), 32'h1);
    chk(32'(st.coord_valid), 32'h1);
    // second reset with a stored user home: restored, counter cleared
    nvm <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(st.user_home), 32'h1);
    chk(cnt_o, 32'h0);
    chk(pos_o, 32'h0);
    rdc(`CWH_OFS_CTRL, 32'h1);
    final_report();
  end
endmodule : test_coordinate_wrap_and_home_manager
